// ---- ser_pkg.sv ----
// package for the status event reporting block: command codes, bit
// positions, reset values and the command/answer carriers.
// assumes a command decoder outside that turns common commands into
// one-cycle requests on the command port.
package ser_pkg;

    // ----------------------------------------------------------------
    // bit positions
    // ----------------------------------------------------------------
    localparam int unsigned BIT_OPC = 0;
    localparam int unsigned BIT_QYE = 2;
    localparam int unsigned BIT_DDE = 3;
    localparam int unsigned BIT_EXE = 4;
    localparam int unsigned BIT_CME = 5;
    localparam int unsigned BIT_ESB = 5;
    localparam int unsigned BIT_MSS = 6;

    // ----------------------------------------------------------------
    // implemented-bit masks and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] EVT_IMPL_MASK = 8'h3d;
    localparam logic [7:0] SRE_IMPL_MASK = 8'hbf;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ----------------------------------------------------------------
    // commands
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SER_CMD_STB_Q,
        SER_CMD_SRE_W,
        SER_CMD_SRE_Q,
        SER_CMD_ESR_Q,
        SER_CMD_ESE_W,
        SER_CMD_ESE_Q,
        SER_CMD_CLS
    } ser_cmd_t;

    typedef struct packed {
        logic valid;
        ser_cmd_t cmd;
        logic bit_sel;
        logic [2:0] bit_idx;
        logic [7:0] data;
    } ser_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ser_rsp_t;

    typedef struct packed {
        logic operation_complete_flag;
        logic query_error_flag;
        logic dde;
        logic execution_error_flag;
        logic command_error_flag;
    } ser_evt_t;

endpackage : ser_pkg

// ---- ser_status.sv ----
// status event reporting block: sticky standard event flags, event and
// service request masks, status byte with summary bits.
// assumes synchronous one-cycle event pulses and one-cycle requests.
//
// Function
// (RULE_01) events set sticky flags until read or cleared
// (RULE_02) event flags read-only; query clears returned flags
// (RULE_03) enable register masks its event register
// (RULE_04) reset clears events, enables, status byte
// (RULE_05) status bit 5 from enabled event flags
// (RULE_06) status bit 6 from enabled status bits
// (RULE_07) enabled status bits raise service request
// (RULE_08) status byte read-only, whole or bit
// (RULE_09) service mask maps onto status byte
// (RULE_10) service mask bit 6 unwritable, reads zero
// (RULE_11) host writes and reads service mask
// (RULE_12) eight sticky flags cleared by read or clear; only five exist here (bits 0, 2, 3, 4, 5)
// (RULE_13) single-bit query clears only that flag
// (RULE_14) bit 0 set on operation complete
// (RULE_15) bit 2 set on output queue loss
// (RULE_16) bit 3 set on command queue overflow
// (RULE_17) bit 4 set on execution error
// (RULE_18) bit 5 set on command parse error
// (RULE_19) event mask ands flags into summary bit
// (RULE_20) clear command clears event flags at once
// (RULE_21) unimplemented bits read zero, ignore events
`timescale 1ns/10ps
`default_nettype none

module ser_status (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire ser_pkg::ser_req_t req_i,
    input wire ser_pkg::ser_evt_t evt_i,
    output ser_pkg::ser_rsp_t rsp_o,
    output logic srq_o,
    output logic [7:0] status_summary_byte_o
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] standard_event_flags_reg;
    logic [7:0] standard_event_flags_next;
    logic [7:0] standard_event_mask_reg;
    logic [7:0] service_request_mask_reg;
    ser_pkg::ser_rsp_t rsp_reg;
    ser_pkg::ser_rsp_t rsp_next;
    logic srq_reg;
    logic [7:0] sb_reg;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire logic do_stb_q = req_i.valid && req_i.cmd == ser_pkg::SER_CMD_STB_Q;
    wire logic do_sre_w = req_i.valid && req_i.cmd == ser_pkg::SER_CMD_SRE_W;
    wire logic do_sre_q = req_i.valid && req_i.cmd == ser_pkg::SER_CMD_SRE_Q;
    wire logic do_esr_q = req_i.valid && req_i.cmd == ser_pkg::SER_CMD_ESR_Q;
    wire logic do_ese_w = req_i.valid && req_i.cmd == ser_pkg::SER_CMD_ESE_W;
    wire logic do_ese_q = req_i.valid && req_i.cmd == ser_pkg::SER_CMD_ESE_Q;
    wire logic do_cls = req_i.valid && req_i.cmd == ser_pkg::SER_CMD_CLS;

    wire logic [7:0] sel_mask = req_i.bit_sel ?
        (8'h01 << req_i.bit_idx) : 8'hff;

    // incoming event pulses placed at their flag positions
    logic [7:0] evt_vec;
    always_comb begin
        evt_vec = 8'h00;
        evt_vec[ser_pkg::BIT_OPC] = evt_i.operation_complete_flag; // RULE_14
        evt_vec[ser_pkg::BIT_QYE] = evt_i.query_error_flag; // RULE_15
        evt_vec[ser_pkg::BIT_DDE] = evt_i.dde; // RULE_16
        evt_vec[ser_pkg::BIT_EXE] = evt_i.execution_error_flag; // RULE_17
        evt_vec[ser_pkg::BIT_CME] = evt_i.command_error_flag; // RULE_18
    end

    // a read clears only what it returned; an event in the same cycle
    // wins so nothing is lost
    wire logic [7:0] clr_vec = do_cls ? 8'hff : // RULE_20
        (do_esr_q ? sel_mask : 8'h00); // RULE_02 RULE_13
    assign standard_event_flags_next = ((standard_event_flags_reg
        & ~clr_vec) | evt_vec) & ser_pkg::EVT_IMPL_MASK; // RULE_01 RULE_12 RULE_21

    // ----------------------------------------------------------------
    // summary logic, from next values so outputs settle in one cycle
    // ----------------------------------------------------------------
    wire logic [7:0] ese_next = do_ese_w ? req_i.data
        : standard_event_mask_reg;
    wire logic [7:0] sre_next = do_sre_w ?
        (req_i.data & ser_pkg::SRE_IMPL_MASK)
        : service_request_mask_reg; // RULE_10 RULE_11
    wire logic esb_next = |(standard_event_flags_next & ese_next); // RULE_03 RULE_19
    logic [7:0] sb_low;
    always_comb begin
        sb_low = 8'h00;
        sb_low[ser_pkg::BIT_ESB] = esb_next; // RULE_05
    end
    wire logic mss_next = |(sb_low & sre_next); // RULE_06 RULE_09
    logic [7:0] sb_next;
    always_comb begin
        sb_next = sb_low;
        sb_next[ser_pkg::BIT_MSS] = mss_next; // RULE_21
    end

    // ----------------------------------------------------------------
    // query answers
    // ----------------------------------------------------------------
    logic [7:0] qval;
    always_comb begin
        qval = 8'h00;
        if (do_stb_q) begin
            qval = sb_reg; // RULE_08
        end else if (do_sre_q) begin
            qval = service_request_mask_reg; // RULE_11
        end else if (do_esr_q) begin
            qval = standard_event_flags_reg;
        end else if (do_ese_q) begin
            qval = standard_event_mask_reg;
        end
        rsp_next.valid = do_stb_q | do_sre_q | do_esr_q | do_ese_q;
        rsp_next.data = req_i.bit_sel ?
            {7'h00, qval[req_i.bit_idx]} : qval;
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            standard_event_flags_reg <= ser_pkg::REG_RESET; // RULE_04
            standard_event_mask_reg <= ser_pkg::REG_RESET;
            service_request_mask_reg <= ser_pkg::REG_RESET;
            sb_reg <= ser_pkg::REG_RESET;
            rsp_reg <= '0;
            srq_reg <= 1'b0;
        end else begin
            standard_event_flags_reg <= standard_event_flags_next;
            standard_event_mask_reg <= ese_next;
            service_request_mask_reg <= sre_next;
            sb_reg <= sb_next;
            rsp_reg <= rsp_next;
            srq_reg <= mss_next; // RULE_07
        end
    end

    assign rsp_o = rsp_reg;
    assign srq_o = srq_reg;
    assign status_summary_byte_o = sb_reg;

endmodule : ser_status

`default_nettype wire

// ---- ser_status_props.sv ----
// checker on the status block ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module ser_status_props (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire ser_pkg::ser_req_t req_i,
    input wire ser_pkg::ser_evt_t evt_i,
    input wire ser_pkg::ser_rsp_t rsp_o,
    input wire logic srq_o,
    input wire logic [7:0] status_summary_byte_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire logic q = req_i.valid && !(req_i.cmd inside
        {ser_pkg::SER_CMD_SRE_W, ser_pkg::SER_CMD_ESE_W, ser_pkg::SER_CMD_CLS});
    wire logic [7:0] sb = status_summary_byte_o;
    a_reset_clears: assert property (disable iff (1'b0)
        rst_i |=> sb == 8'h00 && !srq_o) else $error("reset left status");
    a_spare_bits_zero: assert property ((sb & 8'h9f) == 8'h00)
        else $error("spare status bit set");
    a_srq_is_mss: assert property (srq_o == sb[6])
        else $error("srq differs");
    a_mss_needs_esb: assert property (sb[6] |-> sb[5])
        else $error("summary without event bit");
    a_query_answers: assert property (q |=> rsp_o.valid)
        else $error("no answer");
    a_answer_has_cause: assert property (rsp_o.valid |-> $past(q))
        else $error("stray answer");
    a_bit_form_narrow: assert property (q && req_i.bit_sel
        |=> rsp_o.data[7:1] == 7'h00) else $error("bit answer wide");
    a_stb_old_value: assert property (q && !req_i.bit_sel
        && req_i.cmd == ser_pkg::SER_CMD_STB_Q |=> rsp_o.data == $past(sb))
        else $error("bad status answer");
    a_sre_bit6_zero: assert property (req_i.valid
        && req_i.cmd == ser_pkg::SER_CMD_SRE_Q |=> !rsp_o.data[6])
        else $error("mask bit 6 set");
endmodule : ser_status_props
bind ser_status ser_status_props u_props (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .req_i(req_i), .evt_i(evt_i), .rsp_o(rsp_o),
    .srq_o(srq_o), .status_summary_byte_o(status_summary_byte_o));
`default_nettype wire

// ---- ser_host.sv ----
// host model: issues common commands on the request port
// assumes the caller starts just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module ser_host (
    input wire logic clk_sys_i,
    output var ser_pkg::ser_req_t req_o
);
    initial req_o = '0;
    // held over one edge; released fields show junk, not the last value
    task automatic op(input ser_pkg::ser_req_t r);
        req_o = r;
        @(posedge clk_sys_i);
        #10 req_o = {1'b0, ~r[14:0]};
    endtask : op
endmodule : ser_host
`default_nettype wire

// ---- test_status_event_reporting.sv ----
// testbench: random commands and events against an integer model
// assumes ser_status with its checker bound and the host model
`timescale 1ns/10ps
`default_nettype none
module test_status_event_reporting;
    logic clk_sys_i = 0;
    logic rst_i = 1;
    ser_pkg::ser_evt_t evt_i = '0;
    wire ser_pkg::ser_req_t req_i;
    wire ser_pkg::ser_rsp_t rsp_o;
    wire logic srq_o;
    wire logic [7:0] status_summary_byte_o;
    int mismatches = 0, tests_run = 0, cyc = 0, seed = 32'hd133dee4;
    int flags = 0, standard_event_mask = 0, service_request_mask = 0, sb = 0, i;
    ser_pkg::ser_req_t r;
    ser_pkg::ser_evt_t e;
    ser_host host (.clk_sys_i(clk_sys_i), .req_o(req_i));
    ser_status uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req_i),
        .evt_i(evt_i), .rsp_o(rsp_o), .srq_o(srq_o),
        .status_summary_byte_o(status_summary_byte_o));
    initial forever #50 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic finish_test;
        if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    task automatic check_rsp(input int v);
        tests_run++;
        if (rsp_o.valid !== (v >= 0) || (v >= 0 && rsp_o.data !== v[7:0])) begin
            mismatches++;
            $display("Error %0t: answer", $time);
        end
    endtask : check_rsp
    task automatic check_sb;
        tests_run++;
        if (status_summary_byte_o !== sb[7:0] || srq_o !== sb[6]) begin
            mismatches++;
            $display("Error %0t: status byte", $time);
        end
    endtask : check_sb
    task automatic do_op;
        int v;
        case (r.cmd)
            ser_pkg::SER_CMD_STB_Q: v = sb;
            ser_pkg::SER_CMD_SRE_Q: v = service_request_mask;
            ser_pkg::SER_CMD_ESR_Q: v = flags;
            ser_pkg::SER_CMD_ESE_Q: v = standard_event_mask;
            default: v = -1;
        endcase
        if (v >= 0 && r.bit_sel) v = (v >> r.bit_idx) & 1;
        if (r.cmd == ser_pkg::SER_CMD_ESR_Q)
            flags &= r.bit_sel ? ~(1 << r.bit_idx) : 0;
        if (r.cmd == ser_pkg::SER_CMD_SRE_W) service_request_mask = r.data & 8'hbf;
        if (r.cmd == ser_pkg::SER_CMD_ESE_W) standard_event_mask = r.data;
        if (r.cmd == ser_pkg::SER_CMD_CLS) flags = 0;
        flags |= {e.command_error_flag, e.execution_error_flag, e.dde, e.query_error_flag, 1'b0, e.operation_complete_flag};
        sb = (flags & standard_event_mask) ? 32 : 0;
        sb |= (sb & service_request_mask) ? 64 : 0;
        evt_i = e;
        host.op(r);
        evt_i = '0;
        check_rsp(v);
        @(posedge clk_sys_i);
        #10 check_sb();
    endtask : do_op
    initial begin
        repeat (20) @(posedge clk_sys_i);
        #10 rst_i = 0;
        check_sb();
        for (i = 0; i < 400; i++) begin
            r = 16'($random(seed));
            r.valid = 1'b1;
            // first four are the queries 0,2,3,5 to see reset values
            r.cmd = ser_pkg::ser_cmd_t'(3'(i < 4 ? i + (i + 1) / 2
                : $unsigned($random(seed)) % 7));
            // sparse events; none beside a clear, though an event in that cycle wins
            e = 5'($random(seed) & $random(seed) & $random(seed));
            if (r.cmd == ser_pkg::SER_CMD_CLS) e = '0;
            do_op();
        end
        finish_test();
    end
endmodule : test_status_event_reporting
`default_nettype wire
